//--- core/acr_control_registers.sv
// Converter control registers behind an AHB-Lite slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps

module acr_control_registers (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire logic               comp_in,
	output acr_pkg::acr_analog_t    analog,
	output logic                    irq
);
	localparam int RW = acr_pkg::REG_W;
	localparam int CW = acr_pkg::CHAN_W;

	// Software state
	logic                           done_flag;
	logic                           rate_sel;
	logic                           converter_on;
	logic [CW-1:0]                  channel_select;
	logic                           slow_sel;
	logic [acr_pkg::RESULT_W-1:0]   result;
	logic                           irq_status;
	logic                           irq_mask;

	// Bus phase tracking
	logic                           addr_take;
	logic                           wr_pend;
	logic [31:0]                    wr_addr;
	logic                           rd_wait;
	logic [31:0]                    rd_addr;
	logic [RW-1:0]                  wdata;

	// Decoded effects
	logic                           csr_write;
	logic                           low_write;
	logic                           irq_status_write;
	logic                           irq_mask_write;
	logic                           upper_read;
	logic                           chan_change;
	logic                           restart;
	logic                           next_on;

	// Converter side
	acr_pkg::acr_rate_t             rate;
	logic                           tick;
	logic                           sar_done;
	logic [acr_pkg::RESULT_W-1:0]   sar_result;
	logic                           sar_sample;
	logic [acr_pkg::RESULT_W-1:0]   sar_trial;

	logic [RW-1:0]                  csr_view;
	logic [RW-1:0]                  upper_view;
	logic [RW-1:0]                  lower_view;
	logic [RW-1:0]                  rd_value;

	// Address phase taken only when the bus is ready
	assign addr_take = hsel && hready && (htrans == acr_pkg::HTRANS_NONSEQ);
	assign hreadyout = !rd_wait;
	assign hresp     = acr_pkg::HRESP_OKAY;
	assign wdata     = hwdata[RW-1:0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= acr_pkg::RDATA_ZERO;
		end else if (hready) begin
			wr_pend <= addr_take && hwrite;
			wr_addr <= haddr;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_wait <= 1'b0;
			rd_addr <= acr_pkg::RDATA_ZERO;
		end else begin
			rd_wait <= addr_take && !hwrite;
			if (addr_take) begin
				rd_addr <= haddr;
			end
		end
	end

	// Writes land at the end of a data phase, which never waits
	always_comb begin
		csr_write        = 1'b0;
		low_write        = 1'b0;
		irq_status_write = 1'b0;
		irq_mask_write   = 1'b0;
		if (!wr_pend) begin
			csr_write = 1'b0;
		end else if (wr_addr == acr_pkg::ADDR_CTRL_STATUS) begin
			csr_write = 1'b1;
		end else if (wr_addr == acr_pkg::ADDR_RESULT_LOWER) begin
			low_write = 1'b1;
		end else if (wr_addr == acr_pkg::ADDR_IRQ_STATUS) begin
			irq_status_write = 1'b1;
		end else if (wr_addr == acr_pkg::ADDR_IRQ_MASK) begin
			irq_mask_write = 1'b1;
		end
	end

	assign upper_read  = rd_wait && (rd_addr == acr_pkg::ADDR_RESULT_UPPER);
	assign next_on     = wdata[acr_pkg::CSR_ON_BIT];
	assign chan_change = csr_write
	                     && (wdata[acr_pkg::CSR_CHAN_LSB +: CW] != channel_select);
	assign restart     = (csr_write && next_on) || chan_change;

	// Control bits; reserved bits 4:3 are not stored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rate_sel       <= 1'b0;
			converter_on   <= 1'b0;
			channel_select <= acr_pkg::CHAN_RESET;
		end else if (csr_write) begin
			rate_sel       <= wdata[acr_pkg::CSR_RATE_BIT];
			converter_on   <= next_on;
			channel_select <= wdata[acr_pkg::CSR_CHAN_LSB +: CW];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_sel <= 1'b0;
		end else if (low_write) begin
			slow_sel <= wdata[acr_pkg::LOW_SLOW_BIT];
		end
	end

	// Completion sets over any same-cycle clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_flag <= 1'b0;
		end else if (sar_done) begin
			done_flag <= 1'b1;
		end else if (csr_write || upper_read) begin
			done_flag <= 1'b0;
		end
	end

	// One register holds all ten bits, so both views change together
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result <= acr_pkg::RESULT_RESET;
		end else if (sar_done) begin
			result <= sar_result;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= 1'b0;
		end else if (sar_done) begin
			irq_status <= 1'b1;
		end else if (irq_status_write && wdata[acr_pkg::IRQ_DONE_BIT]) begin
			irq_status <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= 1'b0;
		end else if (irq_mask_write) begin
			irq_mask <= wdata[acr_pkg::IRQ_DONE_BIT];
		end
	end

	assign irq = irq_status && irq_mask;

	// Register views
	always_comb begin
		csr_view                                   = acr_pkg::REG_RESET;
		csr_view[acr_pkg::CSR_DONE_BIT]            = done_flag;
		csr_view[acr_pkg::CSR_RATE_BIT]            = rate_sel;
		csr_view[acr_pkg::CSR_ON_BIT]              = converter_on;
		csr_view[acr_pkg::CSR_CHAN_LSB +: CW]      = channel_select;
		upper_view = result[acr_pkg::RESULT_W-1:acr_pkg::LOW_DATA_W];
		lower_view                                 = acr_pkg::REG_RESET;
		lower_view[acr_pkg::LOW_SLOW_BIT]          = slow_sel;
		lower_view[acr_pkg::LOW_DATA_LSB +: acr_pkg::LOW_DATA_W] =
			result[acr_pkg::LOW_DATA_W-1:0];
	end

	always_comb begin
		rd_value = acr_pkg::REG_RESET;
		if (rd_addr == acr_pkg::ADDR_CTRL_STATUS) begin
			rd_value = csr_view;
		end else if (rd_addr == acr_pkg::ADDR_RESULT_UPPER) begin
			rd_value = upper_view;
		end else if (rd_addr == acr_pkg::ADDR_RESULT_LOWER) begin
			rd_value = lower_view;
		end else if (rd_addr == acr_pkg::ADDR_IRQ_STATUS) begin
			rd_value[acr_pkg::IRQ_DONE_BIT] = irq_status;
		end else if (rd_addr == acr_pkg::ADDR_IRQ_MASK) begin
			rd_value[acr_pkg::IRQ_DONE_BIT] = irq_mask;
		end
	end

	// Read data captured in the wait cycle, held until the next read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= acr_pkg::RDATA_ZERO;
		end else if (rd_wait) begin
			hrdata <= {{(32 - RW){1'b0}}, rd_value};
		end
	end

	// Converter clock selection
	always_comb begin
		if (slow_sel) begin
			rate = acr_pkg::ACR_RATE_QUARTER;
		end else if (rate_sel) begin
			rate = acr_pkg::ACR_RATE_FULL;
		end else begin
			rate = acr_pkg::ACR_RATE_HALF;
		end
	end

	acr_clk_div u_div (
		.clk   (clk),
		.rst_n (rst_n),
		.rate  (rate),
		.tick  (tick)
	);

	acr_sar u_sar (
		.clk     (clk),
		.rst_n   (rst_n),
		.tick    (tick),
		.enable  (converter_on),
		.restart (restart),
		.comp_in (comp_in),
		.sample  (sar_sample),
		.trial   (sar_trial),
		.done    (sar_done),
		.result  (sar_result)
	);

	always_comb begin
		analog.channel = channel_select;
		analog.sample  = sar_sample;
		analog.trial   = sar_trial;
	end

endmodule : acr_control_registers

//--- core/acr_pkg.sv
// Shared constants and types of the converter control register block
package acr_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  IDX_CTRL_STATUS  = 8'h34;
	localparam logic [7:0]  IDX_RESULT_UPPER = 8'h35;
	localparam logic [7:0]  IDX_RESULT_LOWER = 8'h36;
	localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h37;
	localparam logic [7:0]  IDX_IRQ_MASK     = 8'h38;

	localparam logic [31:0] ADDR_CTRL_STATUS  = 32'({IDX_CTRL_STATUS, 2'b00});
	localparam logic [31:0] ADDR_RESULT_UPPER = 32'({IDX_RESULT_UPPER, 2'b00});
	localparam logic [31:0] ADDR_RESULT_LOWER = 32'({IDX_RESULT_LOWER, 2'b00});
	localparam logic [31:0] ADDR_IRQ_STATUS   = 32'({IDX_IRQ_STATUS, 2'b00});
	localparam logic [31:0] ADDR_IRQ_MASK     = 32'({IDX_IRQ_MASK, 2'b00});

	localparam int REG_W    = 8;
	localparam int RESULT_W = 10;
	localparam int CHAN_W   = 3;

	// Control/status fields
	localparam int CSR_DONE_BIT  = 7;
	localparam int CSR_RATE_BIT  = 6;
	localparam int CSR_ON_BIT    = 5;
	localparam int CSR_CHAN_LSB  = 0;
	// Lower result register fields
	localparam int LOW_SLOW_BIT  = 3;
	localparam int LOW_DATA_LSB  = 0;
	localparam int LOW_DATA_W    = 2;
	// Interrupt status/mask field
	localparam int IRQ_DONE_BIT  = 0;

	localparam logic [REG_W-1:0]    REG_RESET    = 8'h00;
	localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
	localparam logic [CHAN_W-1:0]   CHAN_RESET   = 3'h0;
	localparam logic [31:0]         RDATA_ZERO   = 32'h0000_0000;

	// Converter clock ticks spent loading the sample capacitor
	localparam logic [3:0] SAMPLE_TICKS = 4'h4;
	localparam logic [3:0] TICK_ZERO    = 4'h0;
	localparam logic [3:0] TICK_ONE     = 4'h1;
	localparam logic [RESULT_W-1:0] SAR_FIRST_BIT = 10'h200;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	// Converter clock selection
	typedef enum logic [1:0] {
		ACR_RATE_HALF    = 2'h0,
		ACR_RATE_FULL    = 2'h1,
		ACR_RATE_QUARTER = 2'h2
	} acr_rate_t;

	localparam logic [1:0] DIV_HALF_MASK    = 2'h1;
	localparam logic [1:0] DIV_QUARTER_MASK = 2'h3;

	// Signals towards the analog multiplexer and comparator
	typedef struct packed {
		logic [CHAN_W-1:0]   channel;
		logic                sample;
		logic [RESULT_W-1:0] trial;
	} acr_analog_t;

endpackage : acr_pkg

//--- core/acr_clk_div.sv
// Converter clock enable divided down from the system clock
`timescale 1ns/1ps
module acr_clk_div (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  acr_pkg::acr_rate_t    rate,
	output logic                  tick
);
	logic [1:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 2'h0;
		end else begin
			count <= count + 2'h1;
		end
	end

	always_comb begin
		case (rate)
			acr_pkg::ACR_RATE_FULL:    tick = 1'b1;
			acr_pkg::ACR_RATE_QUARTER: tick = (count == acr_pkg::DIV_QUARTER_MASK);
			default:                   tick = ((count & acr_pkg::DIV_HALF_MASK)
			                                   == acr_pkg::DIV_HALF_MASK);
		endcase
	end

endmodule : acr_clk_div

//--- core/acr_sar.sv
// Successive approximation sequencer: sample phase then ten compare steps
`timescale 1ns/1ps
module acr_sar (
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire logic                              tick,
	input  wire logic                              enable,
	input  wire logic                              restart,
	input  wire logic                              comp_in,
	output logic                                   sample,
	output logic [acr_pkg::RESULT_W-1:0]           trial,
	output logic                                   done,
	output logic [acr_pkg::RESULT_W-1:0]           result
);
	typedef enum logic [2:0] {
		ACR_IDLE    = 3'b001,
		ACR_SAMPLE  = 3'b010,
		ACR_CONVERT = 3'b100
	} acr_sar_state_t;

	acr_sar_state_t                state;
	logic [3:0]                    ticks;
	logic [acr_pkg::RESULT_W-1:0]  code;
	logic [acr_pkg::RESULT_W-1:0]  mask;
	logic [acr_pkg::RESULT_W-1:0]  next_code;

	assign next_code = comp_in ? (code | mask) : code;
	assign trial     = code | mask;
	assign sample    = (state == ACR_SAMPLE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ACR_IDLE;
			ticks <= acr_pkg::TICK_ZERO;
			code  <= acr_pkg::RESULT_RESET;
			mask  <= acr_pkg::SAR_FIRST_BIT;
		end else if (!enable || restart) begin
			state <= enable ? ACR_SAMPLE : ACR_IDLE;
			ticks <= acr_pkg::TICK_ZERO;
			code  <= acr_pkg::RESULT_RESET;
			mask  <= acr_pkg::SAR_FIRST_BIT;
		end else if (tick) begin
			case (state)
				ACR_IDLE: begin
					state <= ACR_SAMPLE;
				end
				ACR_SAMPLE: begin
					if (ticks == acr_pkg::SAMPLE_TICKS - acr_pkg::TICK_ONE) begin
						state <= ACR_CONVERT;
						ticks <= acr_pkg::TICK_ZERO;
					end else begin
						ticks <= ticks + acr_pkg::TICK_ONE;
					end
				end
				ACR_CONVERT: begin
					code <= next_code;
					mask <= mask >> 1;
					if (mask[0]) begin
						// Conversions repeat while the converter stays on
						state <= ACR_SAMPLE;
						code  <= acr_pkg::RESULT_RESET;
						mask  <= acr_pkg::SAR_FIRST_BIT;
					end
				end
				default: begin
					state <= ACR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done   <= 1'b0;
			result <= acr_pkg::RESULT_RESET;
		end else begin
			done <= 1'b0;
			if (enable && !restart && tick && state == ACR_CONVERT && mask[0]) begin
				done   <= 1'b1;
				result <= next_code;
			end
		end
	end

endmodule : acr_sar

//--- testbench/acr_analog_model.sv
// Comparator model of the five analog inputs behind the multiplexer
`timescale 1ns/1ps
module acr_analog_model #(
	parameter logic [4:0][9:0] LEVELS = {10'h001, 10'h15a, 10'h2a5, 10'h000, 10'h3ff}
) (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  acr_pkg::acr_analog_t analog,
	output logic                comp_in
);
	logic wobble;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wobble <= 1'b0;
		else
			wobble <= !wobble;
	end

	// Codes above four reach no input, so the comparator gives noise
	assign comp_in = (analog.channel <= 3'h4) ? (LEVELS[analog.channel] >= analog.trial) : wobble;
endmodule : acr_analog_model

//--- testbench/acr_ctrl_assertions.sv
// Bus and converter checks for the converter control registers
`timescale 1ns/1ps
module acr_ctrl_assertions (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           hsel,
	input  wire logic [31:0]    haddr,
	input  wire logic [1:0]     htrans,
	input  wire logic           hwrite,
	input  wire logic [31:0]    hwdata,
	input  wire logic           hready,
	input  wire logic           hreadyout,
	input  wire logic           hresp,
	input  wire logic [31:0]    hrdata,
	input  acr_pkg::acr_analog_t analog,
	input  wire logic           irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic       take;
	logic       rd_cs;
	logic       rd_lo;
	logic       wr_cs;
	logic [2:0] wchan;

	assign take  = hsel && hready && htrans == acr_pkg::HTRANS_NONSEQ;
	assign rd_cs = take && !hwrite && haddr == acr_pkg::ADDR_CTRL_STATUS;
	assign rd_lo = take && !hwrite && haddr == acr_pkg::ADDR_RESULT_LOWER;
	assign wr_cs = take && hwrite && haddr == acr_pkg::ADDR_CTRL_STATUS;
	assign wchan = hwdata[2:0];

	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	write_nowait_a: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	resp_okay_a: assert property (hresp == acr_pkg::HRESP_OKAY)
		else $error("response not okay");
	rdata_upper_a: assert property (take && !hwrite |=> ##1 hrdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	low_reserved_a: assert property (rd_lo |=> ##1 hrdata[7:4] == 4'h0 && !hrdata[2])
		else $error("lower reserved bits set");
	csr_reserved_a: assert property (rd_cs |=> ##1 hrdata[4:3] == 2'h0)
		else $error("control reserved bits set");
	chan_route_a: assert property (wr_cs |=> ##1 analog.channel == $past(wchan))
		else $error("channel not routed");
	off_idle_a: assert property (wr_cs ##1 !hwdata[5] |=> ##1 !analog.sample)
		else $error("sampling while off");
	restart_go_a: assert property (wr_cs ##1 hwdata[5] |=> ##[0:8] analog.sample)
		else $error("no restart after write");

	cover property (rd_lo);
	cover property (wr_cs ##1 hwdata[5]);
	cover property ($rose(irq));
endmodule : acr_ctrl_assertions

bind acr_control_registers acr_ctrl_assertions chk_u (.clk, .rst_n, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .analog, .irq);

//--- testbench/tb.sv
// Self-checking bench for the converter control registers
`timescale 1ns/1ps
module tb;
	localparam logic [4:0][9:0] LV = {10'h001, 10'h15a, 10'h2a5, 10'h000, 10'h3ff};
	localparam logic [31:0] CS = acr_pkg::ADDR_CTRL_STATUS;
	localparam logic [31:0] UP = acr_pkg::ADDR_RESULT_UPPER;
	localparam logic [31:0] LO = acr_pkg::ADDR_RESULT_LOWER;
	localparam int          ST = acr_pkg::SAMPLE_TICKS;

	logic                 clk;
	logic                 rst_n;
	logic                 hsel;
	logic                 hwrite;
	logic                 hready;
	logic                 hreadyout;
	logic                 hresp;
	logic                 comp_in;
	logic                 irq;
	logic [31:0]          haddr;
	logic [31:0]          hwdata;
	logic [31:0]          hrdata;
	logic [1:0]           htrans;
	logic [2:0]           hsize;
	logic [7:0]           rd;
	acr_pkg::acr_analog_t analog;
	int                   n_fail = 0;
	int                   n_checks = 0;
	int                   slen = 0;
	int                   last_len = 0;
	int                   div;

	initial begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end

	assign hready = hreadyout;

	acr_control_registers dut_u (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .comp_in, .analog, .irq);
	acr_analog_model #(.LEVELS(LV)) far_u (.clk, .rst_n, .analog, .comp_in);

	// Length of the last sample phase in system clocks
	always @(posedge clk) begin
		if (analog.sample === 1'b1) begin
			slen <= slen + 1;
		end else if (slen != 0) begin
			last_len <= slen;
			slen <= 0;
		end
	end

	task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= acr_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask : xfer

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_done;
		rd = 8'h00;
		for (int i = 0; i < 100 && rd[7] !== 1'b1; i++)
			xfer(CS, 1'b0, 8'h00);
		chk({7'h0, rd[7]}, 8'h01);
	endtask : wait_done

	task automatic summarize;
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		hsize = 3'h2;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		xfer(UP, 1'b1, 8'hff);
		xfer(32'h0000_0100, 1'b1, 8'hff);
		for (int k = 0; k < 6; k++) begin
			xfer(k < 5 ? CS + 32'(4 * k) : 32'h0000_0100, 1'b0, 8'h00);
			chk(rd, 8'h00);
		end
		xfer(CS, 1'b1, 8'hc7);
		xfer(CS, 1'b0, 8'h00);
		chk(rd, 8'h47);
		xfer(LO, 1'b1, 8'hff);
		xfer(LO, 1'b0, 8'h00);
		chk(rd, 8'h08);
		for (int ch = 0; ch < 5; ch++) begin
			xfer(CS, 1'b1, 8'h20 | 8'(ch));
			// A completion landing with the write survives it, so skip one
			wait_done();
			xfer(UP, 1'b0, 8'h00);
			wait_done();
			xfer(LO, 1'b0, 8'h00);
			chk(rd, {6'h02, LV[ch][1:0]});
			xfer(UP, 1'b0, 8'h00);
			chk(rd, LV[ch][9:2]);
			xfer(CS, 1'b0, 8'h00);
			chk(rd, 8'h20 | 8'(ch));
		end
		wait_done();
		xfer(CS, 1'b1, 8'h24);
		xfer(CS, 1'b0, 8'h00);
		chk(rd, 8'h24);
		for (int m = 0; m < 4; m++) begin
			div = m[1] ? 4 : (m[0] ? 1 : 2);
			xfer(LO, 1'b1, {4'h0, m[1], 3'h0});
			xfer(CS, 1'b1, {1'b0, m[0], 6'h22});
			// Only a sample phase entered from a finished conversion is sure to have full length
			for (int n = 0; n < 3; n++) begin
				wait_done();
				xfer(UP, 1'b0, 8'h00);
			end
			chk({7'h0, last_len == ST * div}, 8'h01);
		end
		@(negedge clk);
		chk({7'h0, irq}, 8'h00);
		xfer(acr_pkg::ADDR_IRQ_MASK, 1'b1, 8'h01);
		@(negedge clk);
		chk({7'h0, irq}, 8'h01);
		xfer(CS, 1'b1, 8'h00);
		xfer(acr_pkg::ADDR_IRQ_STATUS, 1'b1, 8'h01);
		@(negedge clk);
		chk({7'h0, irq}, 8'h00);
		repeat (100) @(posedge clk);
		xfer(CS, 1'b0, 8'h00);
		chk(rd, 8'h00);
		@(negedge clk);
		chk({7'h0, analog.sample}, 8'h00);
		summarize();
	end

	// Whole run is well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		summarize();
	end
endmodule : tb
